// ===== core/health_if.sv
`timescale 1ns/1ps
`default_nettype none

interface health_if;
    import psm_pkg::*;
    bank_t live;
    logic nvm_fault;
    logic check_tick;
    logic flash_tick;
    logic [ERR_W-1:0] errors;
    logic led;

    modport main (output live, nvm_fault, check_tick, flash_tick,
                  input errors, led);
    modport mon (input live, nvm_fault, check_tick, flash_tick,
                 output errors, led);
endinterface

`default_nettype wire

// ===== core/health_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module health_monitor
    import psm_pkg::*;
#(
    parameter logic [PARAM_W-1:0] LIMIT = PARAM_LIMIT
) (
    input wire logic ref_clk,
    input wire logic resetn,
    health_if.mon hb
);
    typedef struct packed {
        logic [ERR_W-1:0] errors;
        logic nvm_seen;
        logic led;
    } mon_s;

    mon_s s;
    mon_s next_s;
    logic [NUM_PARAMS-1:0] over;

    // =========================================================
    // per-parameter range check
    genvar g;
    generate
        for (g = 0; g < NUM_PARAMS; g++)
        begin : g_chk
            assign over[g] = hb.live[g] > LIMIT;
        end
    endgenerate

    always_comb
    begin
        next_s = s;
        // fault arriving on the check tick is folded in, not lost
        if (hb.check_tick)
        begin
            next_s.errors[ERR_RANGE_BIT] = |over;
            next_s.errors[ERR_NVM_BIT] = s.nvm_seen | hb.nvm_fault;
            next_s.nvm_seen = 1'b0;
        end
        else if (hb.nvm_fault)
        begin
            next_s.nvm_seen = 1'b1;
        end
        // steady on when healthy, flashing while errors stand
        if (s.errors == '0)
            next_s.led = 1'b1;
        else if (hb.flash_tick)
            next_s.led = ~s.led;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign hb.errors = s.errors;
    assign hb.led = s.led;
endmodule

`default_nettype wire

// ===== core/parameter_set_manager.sv
`timescale 1ns/1ps
`default_nettype none

module parameter_set_manager
    import psm_pkg::*;
#(
    parameter int CHECK_DIV = CHECK_CYCLES,
    parameter int FLASH_DIV = FLASH_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_bank,
    input wire logic [7:0] cmd_index,
    input wire logic [PARAM_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [PARAM_W-1:0] rsp_data,
    output bank_t live_params,
    output logic live_valid,
    output logic nvm_req,
    output logic nvm_we,
    output logic [ADDR_W-1:0] nvm_addr,
    output logic [PARAM_W-1:0] nvm_wdata,
    input wire logic [PARAM_W-1:0] nvm_rdata,
    input wire logic nvm_ack,
    output logic status_led
);
    typedef enum logic [3:0] {
        ST_BOOT_MARK,
        ST_BOOT_PTR,
        ST_LOAD_START,
        ST_LOAD_MARK,
        ST_LOAD_WORD,
        ST_IDLE,
        ST_SAVE_INVAL,
        ST_SAVE_WORD,
        ST_SAVE_MARK,
        ST_PTR_WORD,
        ST_PTR_MARK
    } state_e;

    typedef struct packed {
        state_e state;
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [PARAM_W-1:0] wdata;
        logic [TMO_W-1:0] tmo;
        bank_t live;
        bank_t shadow;
        logic [IDX_W-1:0] word;
        logic [BANK_W-1:0] bank;
        logic [BANK_W-1:0] boot_ptr;
        logic in_cmd;
        logic op_ready;
        logic rsp_valid;
        logic rsp_ok;
        logic [PARAM_W-1:0] rsp_data;
        logic nvm_fault;
    } ctrl_s;

    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(NVM_TIMEOUT_CYCLES - 1);
    localparam logic [IDX_W-1:0] LAST_WORD = IDX_W'(NUM_PARAMS - 1);
    localparam ctrl_s CTRL_RESET = '{
        state: ST_BOOT_MARK,
        req: 1'b1,
        addr: {DEFAULT_BANK, MARKER_WORD},
        default: '0
    };

    ctrl_s s;
    ctrl_s next_s;
    logic done;
    logic timed_out;
    logic bank_ok;
    logic check_tick;
    logic flash_tick;

    health_if hb();

    // =========================================================
    // helpers
    function automatic logic [ADDR_W-1:0] word_addr(
        logic [BANK_W-1:0] b, logic [IDX_W-1:0] i);
        return {b, 1'b0, i};
    endfunction

    function automatic ctrl_s issue(ctrl_s x, logic we,
        logic [ADDR_W-1:0] a, logic [PARAM_W-1:0] d);
        ctrl_s y;
        y = x;
        y.req = 1'b1;
        y.we = we;
        y.addr = a;
        y.wdata = d;
        y.tmo = '0;
        return y;
    endfunction

    function automatic ctrl_s finish(ctrl_s x, logic ok);
        ctrl_s y;
        y = x;
        y.state = ST_IDLE;
        y.op_ready = 1'b1;
        y.rsp_valid = x.in_cmd;
        y.rsp_ok = ok;
        y.rsp_data = '0;
        y.in_cmd = 1'b0;
        return y;
    endfunction

    // =========================================================
    // command and bank sequencer
    assign done = s.req && nvm_ack;
    assign timed_out = s.req && !nvm_ack && (s.tmo == TMO_LAST);
    assign bank_ok = cmd_bank < NUM_BANKS;
    assign cmd_ready = (s.state == ST_IDLE) && s.op_ready;

    always_comb
    begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        next_s.nvm_fault = 1'b0;
        if (s.req)
            next_s.tmo = s.tmo + 1'b1;
        if (done)
            next_s.req = 1'b0;
        if (timed_out)
        begin
            // memory stopped answering: abandon; keep live bank whole, or load factory bank if still booting
            next_s.req = 1'b0;
            next_s.nvm_fault = 1'b1;
            if (!s.op_ready)
                next_s.live = factory_bank();
            next_s = finish(next_s, 1'b0);
        end
        else
        begin
            case (s.state)
                ST_BOOT_MARK:
                    if (done)
                    begin
                        next_s.bank = DEFAULT_BANK;
                        if (nvm_rdata == VALID_MARKER)
                        begin
                            next_s = issue(next_s, 1'b0,
                                {DEFAULT_BANK, BOOT_WORD}, '0);
                            next_s.state = ST_BOOT_PTR;
                        end
                        else
                        begin
                            next_s.state = ST_LOAD_START;
                        end
                    end
                ST_BOOT_PTR:
                    if (done)
                    begin
                        // a corrupt selector falls back to the default
                        if (nvm_rdata < NUM_BANKS)
                        begin
                            next_s.bank = nvm_rdata[BANK_W-1:0];
                            next_s.boot_ptr = nvm_rdata[BANK_W-1:0];
                        end
                        next_s.state = ST_LOAD_START;
                    end
                ST_LOAD_START:
                    if (s.bank == DEFAULT_BANK)
                    begin
                        next_s.live = factory_bank();
                        next_s = finish(next_s, 1'b1);
                    end
                    else
                    begin
                        next_s = issue(next_s, 1'b0,
                            {s.bank, MARKER_WORD}, '0);
                        next_s.state = ST_LOAD_MARK;
                    end
                ST_LOAD_MARK:
                    if (done)
                    begin
                        if (nvm_rdata == VALID_MARKER)
                        begin
                            next_s.word = '0;
                            next_s = issue(next_s, 1'b0,
                                word_addr(s.bank, '0), '0);
                            next_s.state = ST_LOAD_WORD;
                        end
                        else
                        begin
                            next_s.live = factory_bank();
                            next_s = finish(next_s, 1'b1);
                        end
                    end
                ST_LOAD_WORD:
                    if (done)
                    begin
                        next_s.shadow[s.word] = nvm_rdata;
                        if (s.word == LAST_WORD)
                        begin
                            next_s.live = next_s.shadow;
                            next_s = finish(next_s, 1'b1);
                        end
                        else
                        begin
                            next_s.word = s.word + 1'b1;
                            next_s = issue(next_s, 1'b0,
                                word_addr(s.bank, next_s.word), '0);
                        end
                    end
                ST_IDLE:
                    if (cmd_valid && s.op_ready)
                    begin
                        next_s.rsp_valid = 1'b1;
                        next_s.rsp_ok = 1'b0;
                        next_s.rsp_data = '0;
                        case (cmd_e'(cmd_op))
                            CMD_SET_PARAM:
                                if (cmd_index < NUM_PARAMS)
                                begin
                                    next_s.live[cmd_index[IDX_W-1:0]] =
                                        cmd_data;
                                    next_s.rsp_ok = 1'b1;
                                end
                            CMD_GET_PARAM:
                                if (cmd_index < NUM_PARAMS)
                                begin
                                    next_s.rsp_data =
                                        s.live[cmd_index[IDX_W-1:0]];
                                    next_s.rsp_ok = 1'b1;
                                end
                            CMD_SAVE_LIVE:
                                if (bank_ok && cmd_bank[BANK_W-1:0]
                                    != DEFAULT_BANK)
                                begin
                                    next_s.rsp_valid = 1'b0;
                                    next_s.in_cmd = 1'b1;
                                    next_s.bank = cmd_bank[BANK_W-1:0];
                                    next_s.shadow = s.live;
                                    next_s = issue(next_s, 1'b1,
                                        {cmd_bank[BANK_W-1:0],
                                        MARKER_WORD},
                                        CLEAR_MARKER);
                                    next_s.state = ST_SAVE_INVAL;
                                end
                            CMD_LOAD_BANK:
                                if (bank_ok)
                                begin
                                    next_s.rsp_valid = 1'b0;
                                    next_s.in_cmd = 1'b1;
                                    next_s.bank = cmd_bank[BANK_W-1:0];
                                    next_s.state = ST_LOAD_START;
                                end
                            CMD_SET_BOOT:
                                if (bank_ok)
                                begin
                                    next_s.rsp_valid = 1'b0;
                                    next_s.in_cmd = 1'b1;
                                    next_s.bank = cmd_bank[BANK_W-1:0];
                                    next_s = issue(next_s, 1'b1,
                                        {DEFAULT_BANK, BOOT_WORD},
                                        PARAM_W'(cmd_bank[BANK_W-1:0]));
                                    next_s.state = ST_PTR_WORD;
                                end
                            CMD_GET_BOOT:
                            begin
                                next_s.rsp_data = PARAM_W'(s.boot_ptr);
                                next_s.rsp_ok = 1'b1;
                            end
                            CMD_GET_STATUS:
                            begin
                                next_s.rsp_data =
                                    PARAM_W'(hb.errors);
                                next_s.rsp_ok = 1'b1;
                            end
                            default:
                                next_s.rsp_ok = 1'b0;
                        endcase
                    end
                ST_SAVE_INVAL:
                    if (done)
                    begin
                        next_s.word = '0;
                        next_s = issue(next_s, 1'b1,
                            word_addr(s.bank, '0), s.shadow[0]);
                        next_s.state = ST_SAVE_WORD;
                    end
                ST_SAVE_WORD:
                    if (done)
                    begin
                        if (s.word == LAST_WORD)
                        begin
                            next_s = issue(next_s, 1'b1,
                                {s.bank, MARKER_WORD},
                                VALID_MARKER);
                            next_s.state = ST_SAVE_MARK;
                        end
                        else
                        begin
                            next_s.word = s.word + 1'b1;
                            next_s = issue(next_s, 1'b1,
                                word_addr(s.bank, next_s.word),
                                s.shadow[next_s.word]);
                        end
                    end
                ST_SAVE_MARK:
                    if (done)
                        next_s = finish(next_s, 1'b1);
                ST_PTR_WORD:
                    if (done)
                    begin
                        next_s = issue(next_s, 1'b1,
                            {DEFAULT_BANK, MARKER_WORD}, VALID_MARKER);
                        next_s.state = ST_PTR_MARK;
                    end
                ST_PTR_MARK:
                    if (done)
                    begin
                        next_s.boot_ptr = s.bank;
                        next_s = finish(next_s, 1'b1);
                    end
                default:
                    next_s.state = ST_IDLE;
            endcase
        end
    end

    // live bank is volatile: reset leaves it zero until loaded
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s <= CTRL_RESET;
        else
            s <= next_s;
    end

    // =========================================================
    // self checks and indicator
    tick_divider #(.DIV(CHECK_DIV)) u_check_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(check_tick)
    );

    tick_divider #(.DIV(FLASH_DIV)) u_flash_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(flash_tick)
    );

    assign hb.live = s.live;
    assign hb.nvm_fault = s.nvm_fault;
    assign hb.check_tick = check_tick;
    assign hb.flash_tick = flash_tick;

    health_monitor u_health (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .hb(hb)
    );

    // =========================================================
    // outputs
    assign live_params = s.live;
    assign live_valid = s.op_ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_ok = s.rsp_ok;
    assign rsp_data = s.rsp_data;
    assign nvm_req = s.req;
    assign nvm_we = s.we;
    assign nvm_addr = s.addr;
    assign nvm_wdata = s.wdata;
    assign status_led = hb.led;
endmodule

`default_nettype wire

// ===== core/psm_pkg.sv
package psm_pkg;

    // =========================================================
    // bank geometry
    localparam int NUM_PARAMS = 16;
    localparam int PARAM_W = 16;
    localparam int IDX_W = 4;
    localparam int WORD_W = IDX_W + 1;
    localparam int NUM_CUSTOM = 15;
    localparam int NUM_BANKS = NUM_CUSTOM + 1;
    localparam int BANK_W = 4;
    localparam int ADDR_W = BANK_W + WORD_W;
    localparam logic [BANK_W-1:0] DEFAULT_BANK = 4'h0;
    localparam logic [WORD_W-1:0] MARKER_WORD = 5'h10;
    localparam logic [WORD_W-1:0] BOOT_WORD = 5'h00;
    localparam logic [PARAM_W-1:0] VALID_MARKER = 16'hA5C3;
    localparam logic [PARAM_W-1:0] CLEAR_MARKER = 16'h0000;
    localparam logic [PARAM_W-1:0] FACTORY_BASE = 16'h0100;
    localparam logic [PARAM_W-1:0] PARAM_LIMIT = 16'hF000;

    // =========================================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int NVM_TIMEOUT_US = 10;
    localparam int NVM_TIMEOUT_CYCLES = CLK_HZ / 1_000_000 * NVM_TIMEOUT_US;
    localparam int TMO_W = 10;
    localparam int CHECK_PERIOD_US = 1000;
    localparam int CHECK_CYCLES = CLK_HZ / 1_000_000 * CHECK_PERIOD_US;
    localparam int FLASH_PERIOD_MS = 250;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_PERIOD_MS;

    // =========================================================
    // health flags
    localparam int ERR_W = 2;
    localparam int ERR_RANGE_BIT = 0;
    localparam int ERR_NVM_BIT = 1;

    // =========================================================
    // command codes, in order 0..6
    typedef enum logic [2:0] {
        CMD_SET_PARAM,
        CMD_GET_PARAM,
        CMD_SAVE_LIVE,
        CMD_LOAD_BANK,
        CMD_SET_BOOT,
        CMD_GET_BOOT,
        CMD_GET_STATUS
    } cmd_e;

    typedef logic [NUM_PARAMS-1:0][PARAM_W-1:0] bank_t;

    function automatic bank_t factory_bank();
        bank_t b;
        for (int i = 0; i < NUM_PARAMS; i++)
        begin
            b[i] = FACTORY_BASE + PARAM_W'(i);
        end
        return b;
    endfunction

endpackage

// ===== core/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter int DIV = 1000
) (
    input wire logic ref_clk,
    input wire logic resetn,
    output logic tick
);
    localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } div_s;

    div_s s;
    div_s next_s;

    // =========================================================
    // one-cycle enable every DIV clocks
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == LAST)
        begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;
endmodule

`default_nettype wire

// ===== test/nvm_model.sv
`timescale 1ns/1ps
`default_nettype none

// =========================================
// non-volatile bank memory, contents kept across resets
module nvm_model
    import psm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [ADDR_W-1:0] nvm_addr,
    input wire logic [PARAM_W-1:0] nvm_wdata,
    output logic [PARAM_W-1:0] nvm_rdata,
    output logic nvm_ack
);
    logic [PARAM_W-1:0] mem [2**ADDR_W] = '{default: 16'h0000};
    int cnt;

    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nvm_ack <= 1'b0;
            cnt <= 0;
        end
        else
        begin
            nvm_ack <= 1'b0;
            nvm_rdata <= ~nvm_rdata;
            if (nvm_req && !nvm_ack)
            begin
                if (cnt >= (slow ? 3 : 0))
                begin
                    nvm_ack <= 1'b1;
                    cnt <= 0;
                    nvm_rdata <= mem[nvm_addr];
                    if (nvm_we)
                    begin
                        mem[nvm_addr] <= nvm_wdata;
                    end
                end
                else
                begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/psm_properties.sv
`timescale 1ns/1ps
`default_nettype none

// =========================================
// port checker
module psm_properties
    import psm_pkg::*;
#(
    parameter int CHECK_DIV = CHECK_CYCLES,
    parameter int FLASH_DIV = FLASH_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_bank,
    input wire logic [7:0] cmd_index,
    input wire logic [PARAM_W-1:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_ok,
    input wire bank_t live_params,
    input wire logic live_valid,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [ADDR_W-1:0] nvm_addr,
    input wire logic [PARAM_W-1:0] nvm_wdata,
    input wire logic nvm_ack
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic take;
    assign take = cmd_valid && cmd_ready;

    a_ready_booted: assert property (cmd_ready |-> live_valid)
        else $error("command accepted before boot load");
    a_set_live: assert property (take && cmd_op == CMD_SET_PARAM
        && cmd_index < 16 |=> rsp_valid && rsp_ok
        && live_params[$past(cmd_index[3:0])] == $past(cmd_data))
        else $error("live parameter not written");
    a_bad_bank: assert property (take && cmd_bank > 15
        && cmd_op inside {CMD_SAVE_LIVE, CMD_LOAD_BANK, CMD_SET_BOOT}
        |=> rsp_valid && !rsp_ok) else $error("bad bank accepted");
    a_save_default: assert property (take && cmd_op == CMD_SAVE_LIVE
        && cmd_bank == 0 |=> rsp_valid && !rsp_ok)
        else $error("save to default bank accepted");
    a_bad_op: assert property (take && cmd_op == 3'h7
        |=> rsp_valid && !rsp_ok) else $error("unknown op accepted");
    a_nvm_hold: assert property (nvm_req && !nvm_ack |=> nvm_req
        && $stable(nvm_addr) && $stable(nvm_we) && $stable(nvm_wdata)
        || rsp_valid && !rsp_ok || $rose(live_valid))
        else $error("memory request changed before ack");
    a_idle_stable: assert property (cmd_ready && !cmd_valid
        |=> $stable(live_params)) else $error("live bank changed idle");
    a_default_locked: assert property (nvm_req && nvm_we
        && nvm_addr[8:5] == 4'h0 |-> nvm_addr[4:0] inside {5'h00, 5'h10})
        else $error("default bank area written");
    a_boot_range: assert property (nvm_req && nvm_we
        && nvm_addr == 9'h000 |-> nvm_wdata < 16)
        else $error("boot selector out of range");

    c_save: cover property (take && cmd_op == CMD_SAVE_LIVE ##[1:200] rsp_ok);
    c_load: cover property (take && cmd_op == CMD_LOAD_BANK);
    c_boot: cover property ($rose(live_valid));
endmodule

bind parameter_set_manager psm_properties #(.CHECK_DIV(CHECK_DIV),
    .FLASH_DIV(FLASH_DIV)) u_props (.ref_clk, .resetn, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_bank, .cmd_index, .cmd_data, .rsp_valid,
    .rsp_ok, .live_params, .live_valid, .nvm_req, .nvm_we, .nvm_addr,
    .nvm_wdata, .nvm_ack);

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import psm_pkg::*;
;
    localparam int CHK = 20;
    localparam int FL = 8;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] b;
        logic [7:0] i;
        logic [15:0] d;
        logic ok;
        logic [15:0] q;
    } row_s;
    logic ref_clk = 0, resetn = 0, cmd_valid = 0, slow = 0;
    logic cmd_ready, rsp_valid, rsp_ok, live_valid, status_led;
    logic nvm_req, nvm_we, nvm_ack, r_ok, led_prev;
    logic [2:0] cmd_op = 0;
    logic [7:0] cmd_bank = 0, cmd_index = 0;
    logic [15:0] cmd_data = 0, rsp_data, nvm_wdata, nvm_rdata, r_data;
    logic [ADDR_W-1:0] nvm_addr;
    bank_t live_params;
    int num_errors = 0, checked = 0, cycles = 0, n;
    row_s rows [9] = '{
        '{3'h1, 8'h00, 8'h03, 16'h0000, 1'b1, 16'h0103},
        '{3'h0, 8'h00, 8'h03, 16'h1234, 1'b1, 16'h0000},
        '{3'h1, 8'h00, 8'h03, 16'h0000, 1'b1, 16'h1234},
        '{3'h0, 8'h00, 8'h10, 16'h0001, 1'b0, 16'h0000},
        '{3'h5, 8'h00, 8'h00, 16'h0000, 1'b1, 16'h0000},
        '{3'h4, 8'h10, 8'h00, 16'h0000, 1'b0, 16'h0000},
        '{3'h2, 8'h00, 8'h00, 16'h0000, 1'b0, 16'h0000},
        '{3'h7, 8'h00, 8'h00, 16'h0000, 1'b0, 16'h0000},
        '{3'h6, 8'h00, 8'h00, 16'h0000, 1'b1, 16'h0000}};

    always #5 ref_clk = ~ref_clk;

    parameter_set_manager #(.CHECK_DIV(CHK), .FLASH_DIV(FL)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bank(cmd_bank),
        .cmd_index(cmd_index), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_data(rsp_data), .live_params(live_params),
        .live_valid(live_valid), .nvm_req(nvm_req), .nvm_we(nvm_we),
        .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_ack(nvm_ack), .status_led(status_led));
    nvm_model u_nvm (.ref_clk(ref_clk), .resetn(resetn), .slow(slow),
        .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    // =========================================
    // one command, held until taken, then wait for its answer
    task automatic cmd(input logic [2:0] op, input logic [7:0] b,
        input logic [7:0] i, input logic [15:0] d);
        @(negedge ref_clk);
        {cmd_op, cmd_bank, cmd_index, cmd_data} = {op, b, i, d};
        cmd_valid = 1;
        while (cmd_ready !== 1'b1)
            @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 0;
        while (rsp_valid !== 1'b1)
            @(negedge ref_clk);
        {r_ok, r_data} = {rsp_ok, rsp_data};
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        resetn = 0;
        repeat (4) @(negedge ref_clk);
        check({live_valid, cmd_ready}, 16'h0000);
        check(live_params[5], 16'h0000);
        resetn = 1;
        while (live_valid !== 1'b1)
            @(negedge ref_clk);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        do_reset();
        foreach (rows[k])
        begin
            cmd(rows[k].op, rows[k].b, rows[k].i, rows[k].d);
            check(r_ok, rows[k].ok);
            if (rows[k].op inside {3'h1, 3'h5, 3'h6})
                check(r_data, rows[k].q);
        end
        $display("table test done");
        slow = 1;
        cmd(3'h0, 0, 5, 16'h5555);
        cmd(3'h2, 13, 0, 0);
        check(r_ok, 1'b1);
        slow = 0;
        cmd(3'h0, 0, 5, 16'h0000);
        cmd(3'h3, 13, 0, 0);
        check(live_params[5], 16'h5555);
        cmd(3'h3, 4, 0, 0);
        check(live_params[5], 16'h0105);
        cmd(3'h3, 13, 0, 0);
        cmd(3'h3, 0, 0, 0);
        check(live_params[5], 16'h0105);
        $display("copy test done");
        cmd(3'h4, 13, 0, 0);
        cmd(3'h5, 0, 0, 0);
        check(r_data, 16'h000D);
        do_reset();
        check(live_params[5], 16'h5555);
        check(live_params[3], 16'h1234);
        $display("boot test done");
        cmd(3'h0, 0, 0, 16'hFFFF);
        repeat (2 * CHK) @(negedge ref_clk);
        cmd(3'h6, 0, 0, 0);
        check(r_data[0], 1'b1);
        n = 0;
        led_prev = status_led;
        repeat (5 * FL)
        begin
            @(negedge ref_clk);
            n += (status_led !== led_prev) ? 1 : 0;
            led_prev = status_led;
        end
        check(n >= 4, 1'b1);
        cmd(3'h0, 0, 0, 16'h0100);
        repeat (2 * CHK + 2 * FL) @(negedge ref_clk);
        cmd(3'h6, 0, 0, 0);
        check(r_data, 16'h0000);
        check(status_led, 1'b1);
        $display("health test done");
        print_verdict();
    end
endmodule

`default_nettype wire
